//--- src/acc_top.sv
// register file, synchronisers, event sensing and reference coding for three comparators
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - comparator pins 0 and 1 act as plain gpio until their alternate function is picked; pin 2 always stays gpio
// - negative input from pin only; positive from own pin, comparator 0 pin or reference
// - each output can raise an interrupt or trigger the converter; outputs 0 and 1 can also drive a pin
// - three comparators, each with control and status; shared interrupt registers
// - reference disabled means ground whatever the tap
// - low range: ladder of 31, fraction (tap plus 8) over 31
// - high range: ladder of 23, fraction tap over 23
// - status output bit shows the synchronised comparison result, inverted when the invert bit is set
// - interrupt and trigger sensing are set up independently
// - writing one to a masked status bit clears it; zero does nothing
module acc_top
    import acc_pkg::*;
#(
    parameter int N = ACC_NUM,
    parameter logic [N-1:0] HAS_PIN = 3'h3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ACC_AW-1:0] reg_addr,
    input wire logic [ACC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ACC_DW-1:0] reg_rdata,
    input wire logic [N-1:0] compare_out,
    output logic [N-1:0][1:0] pos_source_sel,
    output logic ref_ladder_en,
    output logic ref_ladder_range,
    output logic [3:0] ref_ladder_tap,
    output logic [4:0] ref_numerator,
    output logic [4:0] ref_denominator,
    input wire logic [N-1:0] alt_function_select,
    input wire logic [N-1:0] gpio_pin_out,
    input wire logic [N-1:0] gpio_pin_oe,
    output logic [N-1:0] pin_out,
    output logic [N-1:0] pin_oe,
    output logic [N-1:0] adc_trigger,
    output logic irq
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] cmp_addr(input int idx, input logic [7:0] off);
        return 8'(int'(ACC_CMP_BASE) + int'(ACC_CMP_STRIDE) * (idx + 1) - int'(ACC_CMP_STRIDE)
            + int'(off));
    endfunction

    function automatic acc_ctl_s ctl_from_word(input logic [ACC_DW-1:0] w);
        acc_ctl_s c;
        c.trig_out_en = w[ACC_CTL_TOEN];
        c.pos_src = w[ACC_CTL_SRC_LSB +: 2];
        c.trig_level = w[ACC_CTL_TSLVAL];
        c.trig_sense = w[ACC_CTL_TSEN_LSB +: 2];
        c.irq_level = w[ACC_CTL_ISLVAL];
        c.irq_sense = w[ACC_CTL_ISEN_LSB +: 2];
        c.invert = w[ACC_CTL_INV];
        return c;
    endfunction

    function automatic logic [ACC_DW-1:0] ctl_to_word(input acc_ctl_s c);
        logic [ACC_DW-1:0] w;
        w = '0;
        w[ACC_CTL_TOEN] = c.trig_out_en;
        w[ACC_CTL_SRC_LSB +: 2] = c.pos_src;
        w[ACC_CTL_TSLVAL] = c.trig_level;
        w[ACC_CTL_TSEN_LSB +: 2] = c.trig_sense;
        w[ACC_CTL_ISLVAL] = c.irq_level;
        w[ACC_CTL_ISEN_LSB +: 2] = c.irq_sense;
        w[ACC_CTL_INV] = c.invert;
        return w;
    endfunction

    // shared by the interrupt path and the trigger path, each with its own mode
    function automatic logic sense_hit(input logic [1:0] mode, input logic lvl,
                                       input logic cur, input logic prev);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            ACC_SENSE_LEVEL: hit = (cur == lvl);
            ACC_SENSE_FALL: hit = prev & ~cur;
            ACC_SENSE_RISE: hit = ~prev & cur;
            ACC_SENSE_BOTH: hit = prev ^ cur;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    acc_ctl_s ctl [N];
    acc_ctl_s next_ctl [N];
    acc_ref_s ref_q;
    acc_ref_s next_ref_q;
    logic [N-1:0] inten;
    logic [N-1:0] next_inten;
    logic [N-1:0] ris;
    logic [N-1:0] next_ris;
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] val_prev;
    logic [N-1:0] next_val_prev;
    logic [N-1:0] val;
    logic [N-1:0] irq_hit;
    logic [N-1:0] trig_hit;
    logic [ACC_DW-1:0] next_rdata;
    logic [N-1:0] next_pin_out;
    logic [N-1:0] next_pin_oe;
    logic [N-1:0] next_adc_trigger;
    logic [4:0] next_ref_numerator;
    logic [4:0] next_ref_denominator;
    logic mis_clear_wr;

    // ------------------------------------------------------------
    // synchroniser and event sensing
    // ------------------------------------------------------------
    // sync1 feeds sync2 only; the raw comparator output is asynchronous
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            val_prev <= '0;
        end else begin
            sync1 <= compare_out;
            sync2 <= sync1;
            val_prev <= next_val_prev;
        end
    end

    // inversion is applied after the synchroniser; flipping it counts as an edge
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sense
            assign val[g] = sync2[g] ^ ctl[g].invert;
            assign irq_hit[g] = sense_hit(ctl[g].irq_sense, ctl[g].irq_level,
                                          val[g], val_prev[g]);
            assign trig_hit[g] = sense_hit(ctl[g].trig_sense, ctl[g].trig_level,
                                           val[g], val_prev[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // register file and outputs, next values
    // ------------------------------------------------------------
    // only the masked status offset clears; raw status is read-only to software
    assign mis_clear_wr = reg_wr && (reg_addr == ACC_OFF_MIS);

    always_comb begin
        next_ctl = ctl;
        next_ref_q = ref_q;
        next_inten = inten;
        next_val_prev = val;
        next_rdata = '0;
        // set wins over a clear landing in the same cycle
        next_ris = (ris & ~(mis_clear_wr ? reg_wdata[N-1:0] : '0)) | irq_hit;
        if (reg_wr && reg_addr == ACC_OFF_INTEN) begin
            next_inten = reg_wdata[N-1:0];
        end
        if (reg_wr && reg_addr == ACC_OFF_REFCTL) begin
            next_ref_q.en = reg_wdata[ACC_REF_EN];
            next_ref_q.range = reg_wdata[ACC_REF_RNG];
            next_ref_q.tap = reg_wdata[ACC_REF_TAP_LSB +: 4];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ACC_OFF_MIS: next_rdata[N-1:0] = ris & inten;
                ACC_OFF_RIS: next_rdata[N-1:0] = ris;
                ACC_OFF_INTEN: next_rdata[N-1:0] = inten;
                ACC_OFF_REFCTL: begin
                    next_rdata[ACC_REF_EN] = ref_q.en;
                    next_rdata[ACC_REF_RNG] = ref_q.range;
                    next_rdata[ACC_REF_TAP_LSB +: 4] = ref_q.tap;
                end
                default: next_rdata = '0;
            endcase
        end
        for (int i = 0; i < N; i++) begin
            if (reg_wr && reg_addr == cmp_addr(i, ACC_CMP_CTL)) begin
                next_ctl[i] = ctl_from_word(reg_wdata);
            end
            if (reg_rd && reg_addr == cmp_addr(i, ACC_CMP_CTL)) begin
                next_rdata = ctl_to_word(ctl[i]);
            end
            if (reg_rd && reg_addr == cmp_addr(i, ACC_CMP_STAT)) begin
                next_rdata[ACC_STAT_OUTPUT_VALUE_BIT] = val[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            // pins without a comparator path stay with the gpio block
            if (HAS_PIN[i] && alt_function_select[i]) begin
                next_pin_out[i] = val[i];
                next_pin_oe[i] = 1'b1;
            end else begin
                next_pin_out[i] = gpio_pin_out[i];
                next_pin_oe[i] = gpio_pin_oe[i];
            end
            next_adc_trigger[i] = ctl[i].trig_out_en & trig_hit[i];
        end
        if (!ref_q.en) begin
            next_ref_numerator = 5'h00;
            next_ref_denominator = ref_q.range ? ACC_LAD_HI_TOTAL : ACC_LAD_LO_TOTAL;
        end else if (!ref_q.range) begin
            next_ref_numerator = 5'({1'b0, ref_q.tap}) + ACC_LAD_LO_OFFSET;
            next_ref_denominator = ACC_LAD_LO_TOTAL;
        end else begin
            next_ref_numerator = 5'({1'b0, ref_q.tap});
            next_ref_denominator = ACC_LAD_HI_TOTAL;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                ctl[i] <= ACC_CTL_RST;
            end
            ref_q <= ACC_REF_RST;
            inten <= '0;
            ris <= '0;
            reg_rdata <= '0;
            pin_out <= '0;
            pin_oe <= '0;
            adc_trigger <= '0;
            ref_numerator <= 5'h00;
            ref_denominator <= ACC_LAD_LO_TOTAL;
        end else begin
            ctl <= next_ctl;
            ref_q <= next_ref_q;
            inten <= next_inten;
            ris <= next_ris;
            reg_rdata <= next_rdata;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            adc_trigger <= next_adc_trigger;
            ref_numerator <= next_ref_numerator;
            ref_denominator <= next_ref_denominator;
        end
    end

    // ------------------------------------------------------------
    // analog side controls
    // ------------------------------------------------------------
    generate
        for (g = 0; g < N; g++) begin : g_src
            // reserved source code falls back to the comparator's own pin
            assign pos_source_sel[g] = (ctl[g].pos_src == 2'h3) ? ACC_SRC_OWN
                                                                : ctl[g].pos_src;
        end
    endgenerate

    assign ref_ladder_en = ref_q.en;
    assign ref_ladder_range = ref_q.range;
    assign ref_ladder_tap = ref_q.tap;
    // level line with no stretching: it drops as soon as software clears the pending bit
    assign irq = |(ris & inten);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_clear_cmp0;
        reg_wr && reg_addr == ACC_OFF_MIS && reg_wdata[0] && !irq_hit[0];
    endsequence

    sequence s_rise_cmp0;
        !rst && ctl[0].trig_sense == ACC_SENSE_RISE && ctl[0].trig_out_en
            && !val_prev[0] && val[0];
    endsequence

    a_sync_two_flop: assert property (
        !$past(rst) && !$past(rst, 2) |-> sync2 == $past(compare_out, 2))
        else $error("synchroniser depth is not two flops");

    a_output_value_bit_readback: assert property (
        reg_rd && reg_addr == cmp_addr(0, ACC_CMP_STAT) |=> reg_rdata[ACC_STAT_OUTPUT_VALUE_BIT]
            == ($past(sync2[0]) ^ $past(ctl[0].invert)))
        else $error("status output bit does not follow comparator");

    a_ref_ground: assert property (
        !ref_q.en |=> ref_numerator == 5'h00)
        else $error("disabled reference is not ground");

    a_ref_low_range: assert property (
        ref_q.en && !ref_q.range |=> ref_denominator == ACC_LAD_LO_TOTAL
            && ref_numerator == 5'($past(ref_q.tap)) + ACC_LAD_LO_OFFSET)
        else $error("low range tap fraction wrong");

    a_ref_high_range: assert property (
        ref_q.en && ref_q.range |=> ref_denominator == ACC_LAD_HI_TOTAL
            && ref_numerator == 5'($past(ref_q.tap)))
        else $error("high range tap fraction wrong");

    a_masked_read: assert property (
        reg_rd && reg_addr == ACC_OFF_MIS |=> reg_rdata[N-1:0] == ($past(ris) & $past(inten))
            && (|reg_rdata[N-1:0]) == $past(irq))
        else $error("masked status is not raw and enable");

    a_w1c_clear: assert property (
        s_clear_cmp0 |=> !ris[0])
        else $error("write one did not clear pending bit");

    a_w0_keep: assert property (
        ris[0] && reg_wr && reg_addr == ACC_OFF_MIS && !reg_wdata[0] |=> ris[0])
        else $error("write zero disturbed pending bit");

    a_pin_gpio_default: assert property (
        !alt_function_select[0] |=> pin_out[0] == $past(gpio_pin_out[0])
            && pin_oe[0] == $past(gpio_pin_oe[0]))
        else $error("pin left gpio control without alternate function");

    a_trigger_edge: assert property (
        s_rise_cmp0 |=> adc_trigger[0])
        else $error("rising trigger missed");

    a_pos_source: assert property (
        reg_wr && reg_addr == cmp_addr(0, ACC_CMP_CTL)
            && reg_wdata[ACC_CTL_SRC_LSB +: 2] != 2'h3
            |=> pos_source_sel[0] == $past(reg_wdata[ACC_CTL_SRC_LSB +: 2]))
        else $error("positive source not taken from control write");

endmodule

`default_nettype wire

//--- src/acc_pkg.sv
// constants and carrier types for the analog comparator control block
package acc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ACC_NUM = 3;
    localparam int ACC_AW = 8;
    localparam int ACC_DW = 32;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_OFF_MIS = 8'h00;
    localparam logic [7:0] ACC_OFF_RIS = 8'h04;
    localparam logic [7:0] ACC_OFF_INTEN = 8'h08;
    localparam logic [7:0] ACC_OFF_REFCTL = 8'h10;
    localparam logic [7:0] ACC_CMP_BASE = 8'h20;
    localparam logic [7:0] ACC_CMP_STRIDE = 8'h20;
    localparam logic [7:0] ACC_CMP_STAT = 8'h00;
    localparam logic [7:0] ACC_CMP_CTL = 8'h04;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ACC_CTL_TOEN = 11;
    localparam int ACC_CTL_SRC_LSB = 9;
    localparam int ACC_CTL_TSLVAL = 7;
    localparam int ACC_CTL_TSEN_LSB = 5;
    localparam int ACC_CTL_ISLVAL = 4;
    localparam int ACC_CTL_ISEN_LSB = 2;
    localparam int ACC_CTL_INV = 1;
    localparam int ACC_STAT_OUTPUT_VALUE_BIT = 1;
    localparam int ACC_REF_EN = 9;
    localparam int ACC_REF_RNG = 8;
    localparam int ACC_REF_TAP_LSB = 0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ACC_SENSE_LEVEL = 2'h0;
    localparam logic [1:0] ACC_SENSE_FALL = 2'h1;
    localparam logic [1:0] ACC_SENSE_RISE = 2'h2;
    localparam logic [1:0] ACC_SENSE_BOTH = 2'h3;
    localparam logic [1:0] ACC_SRC_OWN = 2'h0;
    localparam logic [1:0] ACC_SRC_CMP0 = 2'h1;
    localparam logic [1:0] ACC_SRC_REF = 2'h2;

    // ------------------------------------------------------------
    // ladder figures
    // ------------------------------------------------------------
    localparam logic [4:0] ACC_LAD_LO_TOTAL = 5'h1F;
    localparam logic [4:0] ACC_LAD_LO_OFFSET = 5'h08;
    localparam logic [4:0] ACC_LAD_HI_TOTAL = 5'h17;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic trig_out_en;
        logic [1:0] pos_src;
        logic trig_level;
        logic [1:0] trig_sense;
        logic irq_level;
        logic [1:0] irq_sense;
        logic invert;
    } acc_ctl_s;

    typedef struct packed {
        logic en;
        logic range;
        logic [3:0] tap;
    } acc_ref_s;

    localparam acc_ctl_s ACC_CTL_RST = 10'h000;
    localparam acc_ref_s ACC_REF_RST = 6'h00;

endpackage

//--- verification/acc_analog_model.sv
// behavioural analog front end: input pins, reference ladder and the three comparators
`timescale 1ns/1ps
`default_nettype none

module acc_analog_model
    import acc_pkg::*;
(
    input wire logic [2:0][1:0] pos_source_sel,
    input wire logic [4:0] ref_numerator,
    input wire logic [4:0] ref_denominator,
    // pins are pure analog levels here; their digital input buffers are taken as off
    input wire logic [2:0][11:0] pos_pin_mv,
    input wire logic [2:0][11:0] neg_pin_mv,
    output logic [2:0] compare_out
);
    // ------------------------------------------------------------
    // ladder and comparison
    // ------------------------------------------------------------
    // supply in millivolts, a plain default
    localparam int SUPPLY_MV = 3300;
    int ref_mv;
    int pos_mv;
    always_comb begin
        // a zero denominator is treated as ground rather than dividing by zero
        ref_mv = 0;
        if (ref_denominator != 5'h00) begin
            ref_mv = SUPPLY_MV * ref_numerator / ref_denominator;
        end
        pos_mv = 0;
        for (int k = 0; k < 3; k++) begin
            case (pos_source_sel[k])
                ACC_SRC_CMP0: pos_mv = pos_pin_mv[0];
                ACC_SRC_REF: pos_mv = ref_mv;
                default: pos_mv = pos_pin_mv[k];
            endcase
            // negative side always from the pin
            compare_out[k] = pos_mv > int'(neg_pin_mv[k]);
        end
    end
endmodule

`default_nettype wire

//--- verification/acc_bench.sv
// self-checking testbench for the analog comparator control block
`timescale 1ns/1ps
`default_nettype none

module acc_bench
    import acc_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0] compare_out;
    logic [2:0][1:0] pos_source_sel;
    logic ref_ladder_en;
    logic ref_ladder_range;
    logic [3:0] ref_ladder_tap;
    logic [4:0] ref_numerator;
    logic [4:0] ref_denominator;
    logic [2:0] alt_function_select = 3'h0;
    logic [2:0] gpio_pin_out = 3'h5;
    logic [2:0] gpio_pin_oe = 3'h6;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [2:0] adc_trigger;
    logic irq;
    logic [2:0][11:0] pos_mv = {12'h1F4, 12'h1F4, 12'h1F4};
    logic [2:0][11:0] neg_mv = {12'h3E8, 12'h3E8, 12'h3E8};
    int bad_count = 0;
    int total_checks = 0;
    logic [11:0] rv [7] = '{12'h00F, 12'h100, 12'h200, 12'h20F, 12'h300, 12'h30C, 12'h30F};
    logic [31:0] d;
    int cnt;

    always #12.5 clk = ~clk;

    acc_top acc_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_out(compare_out),
        .pos_source_sel(pos_source_sel), .ref_ladder_en(ref_ladder_en),
        .ref_ladder_range(ref_ladder_range), .ref_ladder_tap(ref_ladder_tap),
        .ref_numerator(ref_numerator), .ref_denominator(ref_denominator),
        .alt_function_select(alt_function_select), .gpio_pin_out(gpio_pin_out),
        .gpio_pin_oe(gpio_pin_oe), .pin_out(pin_out), .pin_oe(pin_oe),
        .adc_trigger(adc_trigger), .irq(irq));

    acc_analog_model acc_analog_model_i (.pos_source_sel(pos_source_sel),
        .ref_numerator(ref_numerator), .ref_denominator(ref_denominator),
        .pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv), .compare_out(compare_out));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic set_mv(input int k, input logic [11:0] p, input logic [11:0] n);
        @(posedge clk);
        pos_mv[k] <= p;
        neg_mv[k] <= n;
        settle();
    endtask

    // edge pulses last one cycle, so every cycle is sampled
    task automatic count_trig(output int c);
        c = 0;
        repeat (6) begin
            @(posedge clk);
            #1;
            c += int'(adc_trigger[0]);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk("irq", irq, 0);
        chk("pin_out", pin_out, 3'h5);
        chk("pin_oe", pin_oe, 3'h6);
        foreach (rv[i]) begin
            wr(ACC_OFF_REFCTL, rv[i]);
            rd(ACC_OFF_REFCTL, d);
            chk("refctl", d, rv[i]);
            chk("ref_num", ref_numerator, !rv[i][9] ? 5'h00 :
                rv[i][8] ? rv[i][3:0] : rv[i][3:0] + 5'h08);
            chk("ladder", {ref_ladder_en, ref_ladder_range, ref_ladder_tap},
                {rv[i][9], rv[i][8], rv[i][3:0]});
            if (rv[i][9]) begin
                chk("ref_den", ref_denominator, rv[i][8] ? 5'h17 : 5'h1F);
            end
        end
        rd(8'h0C, d);
        chk("unmapped", d, 0);
        wr(ACC_OFF_REFCTL, 32'h30C);
        wr(8'h24, 32'h40C);
        wr(8'h44, 32'h200);
        wr(8'h64, 32'h002);
        set_mv(0, 12'h7D0, 12'h3E8);
        chk("sel", pos_source_sel, 6'h06);
        rd(8'h20, d);
        chk("stat0", d[1], 1);
        rd(8'h40, d);
        chk("stat1", d[1], 1);
        rd(8'h60, d);
        chk("stat2", d[1], 1);
        set_mv(0, 12'h7D0, 12'h7D0);
        rd(8'h20, d);
        chk("stat0", d[1], 0);
        wr(8'h24, 32'h008);
        wr(8'h44, 32'h008);
        wr(8'h64, 32'h008);
        set_mv(0, 12'h1F4, 12'h3E8);
        wr(ACC_OFF_MIS, 32'h7);
        rd(ACC_OFF_RIS, d);
        chk("ris", d, 0);
        wr(ACC_OFF_INTEN, 32'h1);
        set_mv(0, 12'h7D0, 12'h3E8);
        chk("irq", irq, 1);
        rd(ACC_OFF_MIS, d);
        chk("mis", d, 1);
        wr(ACC_OFF_MIS, 32'h0);
        rd(ACC_OFF_RIS, d);
        chk("ris", d, 1);
        wr(ACC_OFF_INTEN, 32'h0);
        #1;
        chk("irq", irq, 0);
        rd(ACC_OFF_MIS, d);
        chk("mis", d, 0);
        wr(ACC_OFF_INTEN, 32'h1);
        wr(ACC_OFF_MIS, 32'h1);
        #1;
        chk("irq", irq, 0);
        wr(8'h24, 32'h828);
        set_mv(0, 12'h1F4, 12'h3E8);
        count_trig(cnt);
        chk("trig", cnt, 0);
        @(posedge clk);
        pos_mv[0] <= 12'h7D0;
        count_trig(cnt);
        chk("trig", cnt, 0);
        rd(ACC_OFF_RIS, d);
        chk("ris", d, 1);
        wr(ACC_OFF_MIS, 32'h1);
        @(posedge clk);
        pos_mv[0] <= 12'h1F4;
        count_trig(cnt);
        chk("trig", cnt, 1);
        rd(ACC_OFF_RIS, d);
        chk("ris", d, 0);
        wr(8'h24, 32'h840);
        @(posedge clk);
        pos_mv[0] <= 12'h7D0;
        count_trig(cnt);
        chk("trig", cnt, 1);
        @(posedge clk);
        alt_function_select <= 3'h7;
        settle();
        chk("pin_out", pin_out, 3'h5);
        chk("pin_oe", pin_oe, 3'h7);
        wr(8'h64, 32'h610);
        set_mv(2, 12'h7D0, 12'h3E8);
        chk("sel2", pos_source_sel[2], 2'h0);
        wr(ACC_OFF_MIS, 32'h4);
        rd(ACC_OFF_RIS, d);
        chk("ris2", d[2], 1);
        close_out();
    end
endmodule

`default_nettype wire
